// ---- logic/rrd_params.svh ----
`ifndef RRD_PARAMS_SVH
`define RRD_PARAMS_SVH
`define RRD_DATA_W 8
`define RRD_ADDR_W 8
`define RRD_MSB 7
`define RRD_LSB 0
`define RRD_WRITE_RST 1'b0
`define RRD_ACC_RST 8'h00
`define RRD_CARRY_RST 1'b0
`define RRD_ADDR_RST 8'h00
`define RRD_DATA_RST 8'h00
`endif

// ---- logic/rrd_pkg.sv ----
`include "rrd_params.svh"
package rrd_pkg;
  typedef enum logic [1:0] {
    RRD_OP_NONE = 2'h0,
    RRD_OP_ROTATE = 2'h1,
    RRD_OP_TO_WORKING = 2'h2,
    RRD_OP_WITH_CARRY = 2'h3
  } rrd_op_t;

  typedef struct packed {
    rrd_op_t op;
    logic [`RRD_ADDR_W-1:0] addr;
    logic [`RRD_DATA_W-1:0] operand;
  } rrd_req_t;

  typedef struct packed {
    logic memWrite;
    logic [`RRD_ADDR_W-1:0] memAddr;
    logic [`RRD_DATA_W-1:0] memData;
  } rrd_mem_t;

  typedef struct packed {
    logic [`RRD_DATA_W-1:0] result;
    logic carryOut;
  } rrd_rot_t;
endpackage

// ---- logic/rrd_rotator.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rrd_params.svh"
module rrd_rotator
  import rrd_pkg::*;
(
  input wire rrd_op_t op,
  input wire logic [`RRD_DATA_W-1:0] operand,
  input wire logic carryIn,
  output var rrd_rot_t rot
);
  genvar i;
  logic [`RRD_MSB-1:0] shifted;
  // bits 0..6 take the next higher bit; the top bit depends on the op
  generate
    for (i = 0; i < `RRD_MSB; i++) begin : gShift
      assign shifted[i] = operand[i+1]; // see (RULE1)
    end
  endgenerate
  always_comb begin
    rot.result = {operand[`RRD_LSB], shifted};
    rot.carryOut = carryIn;
    if (op == RRD_OP_WITH_CARRY) begin
      rot.result[`RRD_MSB] = carryIn; // see (RULE5)
      rot.carryOut = operand[`RRD_LSB]; // see (RULE5)
    end else begin
      rot.result[`RRD_MSB] = operand[`RRD_LSB]; // see (RULE1) (RULE2)
    end
  end
endmodule // rrd_rotator
`default_nettype wire

// ---- logic/rrd_datapath.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rrd_params.svh"
//Behaviour
// (RULE1) plain rotate right: bit 0 to bit 7, written back, no flag changes
// (RULE2) rotate to accumulator: same rotation loaded into accumulator, flags unchanged
// (RULE3) rotate to accumulator never writes the data-memory location
// (RULE4) carry rotate treats byte plus carry as one nine-bit chain shifted right
// (RULE5) carry rotate: bit 0 to carry, carry to bit 7, written back
module rrd_datapath
  import rrd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire rrd_req_t req,
  output rrd_mem_t mem,
  output logic [`RRD_DATA_W-1:0] acc,
  output logic carry
);
  typedef struct packed {
    rrd_mem_t mem;
    logic [`RRD_DATA_W-1:0] acc;
    logic carry;
  } rrd_state_t;

  rrd_state_t state;
  rrd_state_t next_state;
  rrd_rot_t rot;

  // op decoding shared by the properties below
  function automatic logic opWritesMem(input rrd_op_t op);
    return (op == RRD_OP_ROTATE) || (op == RRD_OP_WITH_CARRY);
  endfunction

  function automatic logic opLoadsAcc(input rrd_op_t op);
    return op == RRD_OP_TO_WORKING;
  endfunction

  function automatic logic opUpdatesCarry(input rrd_op_t op);
    return op == RRD_OP_WITH_CARRY;
  endfunction

  rrd_rotator uRot (
    .op(req.op),
    .operand(req.operand),
    .carryIn(state.carry),
    .rot(rot)
  );

  always_comb begin
    next_state = state;
    next_state.mem.memWrite = 1'b0;
    case (req.op)
      RRD_OP_ROTATE: begin
        next_state.mem.memWrite = 1'b1; // see (RULE1)
        next_state.mem.memAddr = req.addr;
        next_state.mem.memData = rot.result;
      end
      RRD_OP_TO_WORKING: begin
        next_state.acc = rot.result; // see (RULE2) (RULE3)
      end
      RRD_OP_WITH_CARRY: begin
        next_state.mem.memWrite = 1'b1; // see (RULE4)
        next_state.mem.memAddr = req.addr;
        next_state.mem.memData = rot.result;
        next_state.carry = rot.carryOut; // see (RULE5)
      end
      default: begin
        next_state.mem.memWrite = 1'b0;
      end
    endcase
  end

  // synchronous reset; a single low edge clears everything
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state.mem.memWrite <= `RRD_WRITE_RST;
      state.mem.memAddr <= `RRD_ADDR_RST;
      state.mem.memData <= `RRD_DATA_RST;
      state.acc <= `RRD_ACC_RST;
      state.carry <= `RRD_CARRY_RST;
    end else begin
      state <= next_state;
    end
  end

  assign mem = state.mem;
  assign acc = state.acc;
  assign carry = state.carry;

  // sampled rst_b in each trigger: the edge that resets must not start an attempt
  AST_RR_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE1)
    rst_b && req.op == RRD_OP_ROTATE |=>
      mem.memWrite
      && mem.memAddr == $past(req.addr)
      && mem.memData == {$past(req.operand[`RRD_LSB]),
                         $past(req.operand[`RRD_MSB:`RRD_LSB+1])}
      && carry == $past(carry))
    else $error("rotate right result wrong");

  AST_RR_TOP_BIT: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE1)
    rst_b && req.op == RRD_OP_ROTATE |=>
      mem.memData[`RRD_MSB] == $past(req.operand[`RRD_LSB]))
    else $error("rotate right top bit wrong");

  AST_RR_LOW_BITS: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE1)
    rst_b && req.op == RRD_OP_ROTATE |=>
      mem.memData[`RRD_MSB-1:`RRD_LSB] == $past(req.operand[`RRD_MSB:`RRD_LSB+1]))
    else $error("rotate right low bits wrong");

  AST_RR_ACC_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE1)
    rst_b && req.op == RRD_OP_ROTATE |=>
      $stable(acc))
    else $error("rotate right touched accumulator");

  AST_RR_CARRY_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE1)
    rst_b && req.op == RRD_OP_ROTATE |=>
      $stable(carry))
    else $error("rotate right touched carry");

  AST_RRA_ACC: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE2)
    rst_b && req.op == RRD_OP_TO_WORKING |=>
      acc == {$past(req.operand[`RRD_LSB]),
              $past(req.operand[`RRD_MSB:`RRD_LSB+1])}
      && carry == $past(carry))
    else $error("rotate to accumulator wrong");

  AST_RRA_TOP_BIT: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE2)
    rst_b && req.op == RRD_OP_TO_WORKING |=>
      acc[`RRD_MSB] == $past(req.operand[`RRD_LSB]))
    else $error("accumulator top bit wrong");

  AST_RRA_LOW_BITS: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE2)
    rst_b && req.op == RRD_OP_TO_WORKING |=>
      acc[`RRD_MSB-1:`RRD_LSB] == $past(req.operand[`RRD_MSB:`RRD_LSB+1]))
    else $error("accumulator low bits wrong");

  AST_RRA_CARRY_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE2)
    rst_b && req.op == RRD_OP_TO_WORKING |=>
      $stable(carry))
    else $error("rotate to accumulator touched carry");

  // the source byte is only safe if no write strobe leaves the block
  AST_RRA_NOWRITE: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE3)
    rst_b && req.op == RRD_OP_TO_WORKING |=>
      !mem.memWrite)
    else $error("memory written by accumulator rotate");

  AST_RRA_MEM_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE3)
    rst_b && req.op == RRD_OP_TO_WORKING |=>
      $stable(mem.memAddr)
      && $stable(mem.memData))
    else $error("accumulator rotate moved write bus");

  AST_WRITE_BUS_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE3)
    rst_b && !opWritesMem(req.op) |=>
      $stable(mem.memAddr)
      && $stable(mem.memData))
    else $error("write bus moved without a write");

  // byte plus carry as one chain: {data, carry} equals {old carry, old byte}
  AST_RRC_CHAIN: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE4)
    rst_b && req.op == RRD_OP_WITH_CARRY |=>
      {mem.memData, carry} == {$past(carry), $past(req.operand)})
    else $error("carry chain rotate wrong");

  AST_RRC_LOW_BITS: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE4)
    rst_b && req.op == RRD_OP_WITH_CARRY |=>
      mem.memData[`RRD_MSB-1:`RRD_LSB] == $past(req.operand[`RRD_MSB:`RRD_LSB+1]))
    else $error("carry rotate low bits wrong");

  AST_RRC_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE5)
    rst_b && req.op == RRD_OP_WITH_CARRY |=>
      mem.memWrite
      && mem.memAddr == $past(req.addr)
      && acc == $past(acc))
    else $error("carry rotate writeback wrong");

  AST_RRC_CARRY_OUT: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE5)
    rst_b && req.op == RRD_OP_WITH_CARRY |=>
      carry == $past(req.operand[`RRD_LSB]))
    else $error("carry rotate lost its low bit");

  AST_RRC_CARRY_IN: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE5)
    rst_b && req.op == RRD_OP_WITH_CARRY |=>
      mem.memData[`RRD_MSB] == $past(carry))
    else $error("carry rotate top bit wrong");

  AST_ACC_ONLY_RRA: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE5)
    rst_b && !opLoadsAcc(req.op) |=>
      $stable(acc))
    else $error("accumulator changed by another op");

  AST_CARRY_ONLY_RRC: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE2)
    rst_b && !opUpdatesCarry(req.op) |=>
      $stable(carry))
    else $error("carry changed by another op");

  // a strobe that stood two cycles would write the same byte twice
  AST_WRITE_ONE_SHOT: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE1)
    rst_b && mem.memWrite && !opWritesMem(req.op) |=>
      !mem.memWrite)
    else $error("write strobe held too long");

  AST_WRITE_CAUSE: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE3)
    rst_b && mem.memWrite |->
      opWritesMem($past(req.op)))
    else $error("write strobe without a writing op");

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // see (RULE1)
    rst_b && req.op == RRD_OP_NONE |=>
      !mem.memWrite
      && $stable(carry)
      && $stable(acc)
      && $stable(mem.memAddr)
      && $stable(mem.memData))
    else $error("idle cycle changed state");

  // no disable here: this one must run while reset is low
  AST_RESET_CLEAR: assert property (@(posedge clk)
    !rst_b |=>
      mem.memWrite == `RRD_WRITE_RST
      && mem.memAddr == `RRD_ADDR_RST
      && mem.memData == `RRD_DATA_RST
      && acc == `RRD_ACC_RST
      && carry == `RRD_CARRY_RST)
    else $error("reset left state behind");
endmodule // rrd_datapath
`default_nettype wire

// ---- sim/tb_rotate_right_datapath.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rrd_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_rotate_right_datapath
  import rrd_pkg::*;
;
  logic clk;
  logic rst_b;
  rrd_req_t req;
  rrd_mem_t mem;
  logic [7:0] acc;
  logic carry;
  int miscompares;
  int checks;
  int cycles;

  rrd_datapath u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .req(req),
    .mem(mem),
    .acc(acc),
    .carry(carry)
  );

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task end_sim;
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 200) begin
      miscompares++;
      end_sim;
    end
  end

  // idle cycle after each op so a request is sampled exactly once
  task go(input rrd_op_t op, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{op, a, d};
    @(posedge clk) req <= '{RRD_OP_NONE, 8'h00, 8'h00};
    #1;
  endtask

  task t_to_acc;
    go(RRD_OP_TO_WORKING, 8'h03, 8'h01);
    `CHK(acc, 8'h80)
    `CHK(mem.memWrite, 1'h0)
    `CHK(carry, 1'h0)
  endtask

  task t_plain;
    go(RRD_OP_ROTATE, 8'h05, 8'h81);
    `CHK(mem.memData, 8'hc0)
    `CHK(mem.memAddr, 8'h05)
    `CHK(mem.memWrite, 1'h1)
    `CHK(acc, 8'h80)
    `CHK(carry, 1'h0)
  endtask

  // carry set by one carry rotate must hold through the other ops and steer the next carry rotate
  task t_carry;
    go(RRD_OP_WITH_CARRY, 8'h07, 8'h01);
    `CHK(mem.memData, 8'h00)
    `CHK(carry, 1'h1)
    `CHK(mem.memAddr, 8'h07)
    `CHK(acc, 8'h80)
    go(RRD_OP_ROTATE, 8'h05, 8'h01);
    `CHK(mem.memData, 8'h80)
    `CHK(carry, 1'h1)
    go(RRD_OP_TO_WORKING, 8'h03, 8'h03);
    `CHK(acc, 8'h81)
    `CHK(mem.memData, 8'h80)
    `CHK(carry, 1'h1)
    go(RRD_OP_WITH_CARRY, 8'h07, 8'h02);
    `CHK(mem.memData, 8'h81)
    `CHK(carry, 1'h0)
    `CHK(mem.memWrite, 1'h1)
  endtask

  // one-edge reset in mid-run must clear carry and accumulator left by earlier ops
  task t_reset;
    go(RRD_OP_WITH_CARRY, 8'h09, 8'h03);
    `CHK(mem.memData, 8'h01)
    `CHK(carry, 1'h1)
    @(posedge clk) rst_b <= 1'h0;
    @(posedge clk) rst_b <= 1'h1;
    #1;
    `CHK({mem.memWrite, mem.memAddr, mem.memData}, 17'h00000)
    `CHK({acc, carry}, 9'h000)
  endtask

  initial begin
    rst_b = 1'h0;
    req = '{RRD_OP_NONE, 8'h00, 8'h00};
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    #1;
    `CHK({mem.memWrite, mem.memAddr, mem.memData}, 17'h00000)
    `CHK({acc, carry}, 9'h000)
    t_to_acc;
    t_plain;
    t_carry;
    t_reset;
    end_sim;
  end
endmodule // tb_rotate_right_datapath
`default_nettype wire
